// *** sbma_pkg.sv ***
`default_nettype none
package sbma_pkg;

    // apb map, byte addresses
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned DATA_W     = 32;
    localparam logic [11:0] PARK_OFFS  = 12'h000;
    localparam logic [11:0] STAT_OFFS  = 12'h004;
    localparam logic [31:0] PARK_RESET = 32'h0000_0000;
    // only documented fields are writable, reserved bits stay zero
    localparam logic [31:0] PARK_WMASK = 32'h033C_7F00;

    // arbitration sizing
    localparam int unsigned NUM_M = 2;
    localparam int unsigned M_CPU = 0;
    localparam int unsigned M_DMA = 1;
    localparam int unsigned EXP_W = 4;
    localparam int unsigned CNT_W = 16;

    // park/priority register layout
    typedef struct packed {
        logic [5:0] rsv_hi;
        logic       boost_en;
        logic       wide_bc;
        logic [1:0] rsv_mid;
        logic [1:0] dma_prio;
        logic [1:0] cpu_prio;
        logic [2:0] rsv_lo;
        logic       fixed_mode;
        logic       timeout_en;
        logic       park_select;
        logic [3:0] lock_exp;
        logic [7:0] rsv_low;
    } sbma_park_t;

    // bus owner / pointer encoding
    typedef enum logic [1:0] {
        OWN_NONE = 2'b00,
        OWN_CPU  = 2'b01,
        OWN_DMA  = 2'b10
    } sbma_owner_t;

    // read-only status word
    typedef struct packed {
        logic [25:0] rsv;
        logic [1:0]  locks;
        sbma_owner_t ptr;
        sbma_owner_t owner;
    } sbma_status_t;

endpackage : sbma_pkg
`default_nettype wire

// *** sbma_lockout_ctr.sv ***
`default_nettype none
module sbma_lockout_ctr #(
    parameter int unsigned CNT_W = sbma_pkg::CNT_W,
    parameter int unsigned EXP_W = sbma_pkg::EXP_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             enable,
    input  wire logic             deny,
    input  wire logic [EXP_W-1:0] limit_exp,
    output logic                  locked
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] limit;
    logic             lock_r;
    logic             lock_nxt;

    // denied-cycle count, saturates once locked
    always_comb
    begin
        limit     = {{(CNT_W-1){1'b0}}, 1'b1} << limit_exp;
        count_nxt = count_r;
        lock_nxt  = lock_r;
        if (!enable || !deny)
        begin
            count_nxt = '0;
            lock_nxt  = 1'b0;
        end
        else if (!lock_r)
        begin
            count_nxt = CNT_W'(count_r + 1'b1);
            // limit is two to the exponent
            lock_nxt  = (count_nxt == limit);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r <= '0;
            lock_r  <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            lock_r  <= lock_nxt;
        end
    end

    assign locked = lock_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_lock_at_limit: assert property (lock_r |-> count_r == limit)
        else $error("lock set away from limit");
    a_no_count_off: assert property (!enable |=> (count_r == '0) && !lock_r)
        else $error("counting while disabled");

endmodule : sbma_lockout_ctr
`default_nettype wire

// *** sbma_apb_regs.sv ***
`default_nettype none
module sbma_apb_regs (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire sbma_pkg::sbma_status_t status,
    output sbma_pkg::sbma_park_t      cfg
);

    sbma_pkg::sbma_park_t park_r;
    sbma_pkg::sbma_park_t park_nxt;
    sbma_pkg::sbma_park_t wr_view;
    logic [31:0]          prdata_r;
    logic [31:0]          prdata_nxt;
    logic                 hit_park;
    logic                 hit_stat;
    logic                 access;

    // decode; unaligned or unmapped addresses miss
    assign hit_park = (paddr == sbma_pkg::PARK_OFFS);
    assign hit_stat = (paddr == sbma_pkg::STAT_OFFS);
    assign access   = psel && penable;
    assign wr_view  = pwdata;

    // write in access phase, read data latched in setup
    always_comb
    begin
        park_nxt   = park_r;
        prdata_nxt = prdata_r;
        if (access && pwrite && hit_park)
            park_nxt = sbma_pkg::sbma_park_t'(pwdata & sbma_pkg::PARK_WMASK);
        if (psel && !penable && !pwrite)
            prdata_nxt = hit_park ? park_r : (hit_stat ? status : 32'h0000_0000);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            park_r   <= sbma_pkg::PARK_RESET;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            park_r   <= park_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // zero wait states; status is read-only so writes to it error
    assign pready  = 1'b1;
    assign pslverr = access && !(hit_park || (hit_stat && !pwrite));
    assign prdata  = prdata_r;
    assign cfg     = park_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_wide_follow: assert property (access && pwrite && hit_park |=> cfg.wide_bc == $past(wr_view.wide_bc))
        else $error("byte count width not updated");
    a_reserved_zero: assert property ((cfg & ~sbma_pkg::PARK_WMASK) == 32'h0000_0000)
        else $error("reserved bit set");

endmodule : sbma_apb_regs
`default_nettype wire

// *** sbma_arbiter.sv ***
// Operation
// - the boost enable bit lets the dma bandwidth request raise dma priority, otherwise it is ignored.
// - the wide byte count bit is driven to the dma to choose 24-bit or 16-bit byte counters.
// - the dma priority field encodes 00 lowest up to 11 highest.
// - the cpu priority field uses the same encoding.
// - the fixed mode bit selects round-robin at 0 and fixed priority at 1.
// - with timeout enabled, denied cycles are counted per master and a master at the limit gets access.
// - with no requests the pointer parks on the last active master, or on the top-priority one if park select is set.
// - the lock-out limit is two raised to the exponent field in denied cycles.
// - after reset the dma master ranks above the cpu master.
// - equal priority fields fall back to the reset order with dma first.
// - requester port 1 is the dma controller and port 0 is the processor core.
// - round-robin is the reset mode and a master finishing a transfer drops to lowest priority.
// - in fixed mode the top requester wins and keeps the bus until its transfers are done.
// - in fixed mode a lock switches to round-robin until all locks clear, then fixed resumes.
// - in round-robin mode timeout enable and lock-out time have no effect.
`default_nettype none
module sbma_arbiter #(
    parameter int unsigned NUM_M = sbma_pkg::NUM_M
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_req,
    input  wire logic        dma_req,
    input  wire logic        dma_boost_req,
    input  wire logic        bus_xfer_done,
    output logic             cpu_gnt,
    output logic             dma_gnt,
    output sbma_pkg::sbma_owner_t arb_ptr,
    output logic             dma_wide_byte_count,
    output logic             dma_bandwidth_boost_enable
);

    sbma_pkg::sbma_park_t   cfg;
    sbma_pkg::sbma_status_t status;
    sbma_pkg::sbma_owner_t  owner_r;
    sbma_pkg::sbma_owner_t  owner_nxt;
    sbma_pkg::sbma_owner_t  ptr_r;
    sbma_pkg::sbma_owner_t  ptr_nxt;
    sbma_pkg::sbma_owner_t  rr_last_r;
    sbma_pkg::sbma_owner_t  rr_last_nxt;
    sbma_pkg::sbma_owner_t  top_prio;
    sbma_pkg::sbma_owner_t  rr_pick;
    sbma_pkg::sbma_owner_t  win;
    sbma_pkg::sbma_owner_t  other;
    logic [NUM_M-1:0]       req_v;
    logic [NUM_M-1:0]       gnt_v;
    logic [NUM_M-1:0]       lock_v;
    logic                   any_lock;
    logic                   eff_rr;
    logic                   prio_eq;
    logic                   boost_act;
    logic                   dma_first;
    logic                   own_req;
    logic                   other_req;
    logic                   count_en;

    // register file over apb
    sbma_apb_regs u_regs (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .status  (status),
        .cfg     (cfg)
    );

    // port 0 is the core, port 1 the dma
    assign req_v[sbma_pkg::M_CPU] = cpu_req;
    assign req_v[sbma_pkg::M_DMA] = dma_req;
    assign gnt_v[sbma_pkg::M_CPU] = (owner_r == sbma_pkg::OWN_CPU);
    assign gnt_v[sbma_pkg::M_DMA] = (owner_r == sbma_pkg::OWN_DMA);

    // counters run only in fixed mode
    assign count_en = cfg.fixed_mode && cfg.timeout_en;

    // one anti-lock-out counter per master
    for (genvar i = 0; i < NUM_M; i++)
    begin : g_lock
        sbma_lockout_ctr u_ctr (
            .pclk      (pclk),
            .presetn   (presetn),
            .enable    (count_en),
            .deny      (req_v[i] && !gnt_v[i]),
            .limit_exp (cfg.lock_exp),
            .locked    (lock_v[i])
        );
    end

    // effective priority and mode
    always_comb
    begin
        any_lock  = |lock_v;
        eff_rr    = !cfg.fixed_mode || any_lock;
        prio_eq   = (cfg.dma_prio == cfg.cpu_prio);
        boost_act = cfg.boost_en && dma_boost_req;
        dma_first = boost_act || prio_eq || (cfg.dma_prio > cfg.cpu_prio);
        top_prio  = dma_first ? sbma_pkg::OWN_DMA : sbma_pkg::OWN_CPU;
        // last finisher goes to the back
        rr_pick   = (rr_last_r == sbma_pkg::OWN_DMA) ? sbma_pkg::OWN_CPU : sbma_pkg::OWN_DMA;
    end

    // winner among requesters
    always_comb
    begin
        win = sbma_pkg::OWN_NONE;
        if (cpu_req && dma_req)
            win = eff_rr ? rr_pick : top_prio;
        else if (dma_req)
            win = sbma_pkg::OWN_DMA;
        else if (cpu_req)
            win = sbma_pkg::OWN_CPU;
    end

    // next owner, pointer and rotation state
    // a holder that drops its request frees the bus at once; waiting for a
    // done pulse as well would leave the bus idle for a cycle
    always_comb
    begin
        own_req     = 1'b0;
        other_req   = 1'b0;
        other       = sbma_pkg::OWN_NONE;
        unique case (owner_r)
            sbma_pkg::OWN_NONE:
            begin
                own_req = 1'b0;
            end
            sbma_pkg::OWN_CPU:
            begin
                own_req   = cpu_req;
                other_req = dma_req;
                other     = sbma_pkg::OWN_DMA;
            end
            sbma_pkg::OWN_DMA:
            begin
                own_req   = dma_req;
                other_req = cpu_req;
                other     = sbma_pkg::OWN_CPU;
            end
            default:
            begin
                own_req = 1'b0;
            end
        endcase
        owner_nxt = owner_r;
        // re-arbitrate only when the owner lets go
        if (owner_r == sbma_pkg::OWN_NONE || !own_req)
            owner_nxt = win;
        // hand over at transfer end in rotation
        else if (bus_xfer_done && eff_rr && other_req)
            owner_nxt = other;
        // otherwise the owner keeps the bus
        rr_last_nxt = rr_last_r;
        if (bus_xfer_done && owner_r != sbma_pkg::OWN_NONE)
            rr_last_nxt = owner_r;
        if (owner_nxt != sbma_pkg::OWN_NONE)
            ptr_nxt = owner_nxt;
        else if (cfg.park_select)
            ptr_nxt = top_prio;
        else if (owner_r != sbma_pkg::OWN_NONE)
            ptr_nxt = owner_r;
        else
            ptr_nxt = ptr_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            owner_r   <= sbma_pkg::OWN_NONE;
            ptr_r     <= sbma_pkg::OWN_DMA;
            rr_last_r <= sbma_pkg::OWN_CPU;
        end
        else
        begin
            owner_r   <= owner_nxt;
            ptr_r     <= ptr_nxt;
            rr_last_r <= rr_last_nxt;
        end
    end

    // grants decoded from one owner register, so never two
    assign cpu_gnt = gnt_v[sbma_pkg::M_CPU];
    assign dma_gnt = gnt_v[sbma_pkg::M_DMA];
    assign arb_ptr = ptr_r;

    // dma configuration straight from the register
    assign dma_wide_byte_count        = cfg.wide_bc;
    assign dma_bandwidth_boost_enable = cfg.boost_en;

    // status word seen by software
    always_comb
    begin
        status       = '0;
        status.locks = lock_v;
        status.ptr   = ptr_r;
        status.owner = owner_r;
    end

    // checks see the registered owner, one cycle after arbitration
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_grant_onehot: assert property (!(cpu_gnt && dma_gnt))
        else $error("two masters granted");

    a_grant_hold: assert property (
        owner_r != sbma_pkg::OWN_NONE && own_req && !bus_xfer_done |=> owner_r == $past(owner_r))
        else $error("grant moved during transfer");

    a_fixed_prio: assert property (
        owner_r == sbma_pkg::OWN_NONE && cpu_req && dma_req && cfg.fixed_mode && !any_lock
        && !boost_act && cfg.cpu_prio > cfg.dma_prio |=> owner_r == sbma_pkg::OWN_CPU)
        else $error("fixed priority not honoured");

    a_equal_default: assert property (
        owner_r == sbma_pkg::OWN_NONE && cpu_req && dma_req && cfg.fixed_mode && !any_lock
        && prio_eq |=> owner_r == sbma_pkg::OWN_DMA)
        else $error("equal fields did not favour dma");

    a_reset_order: assert property (
        $rose(presetn) |-> dma_first && ptr_r == sbma_pkg::OWN_DMA)
        else $error("reset order not dma first");

    a_rr_rotate: assert property (
        !cfg.fixed_mode && owner_r == sbma_pkg::OWN_DMA && bus_xfer_done && cpu_req
        |=> owner_r == sbma_pkg::OWN_CPU)
        else $error("round-robin did not rotate");

    a_lock_to_rr: assert property (
        cfg.fixed_mode && any_lock && owner_r != sbma_pkg::OWN_NONE && own_req && bus_xfer_done
        && other_req |=> owner_r == $past(other))
        else $error("locked master not served");

    a_park_last: assert property (
        !cpu_req && !dma_req && !cfg.park_select && owner_r != sbma_pkg::OWN_NONE
        |=> ptr_r == $past(owner_r) && owner_r == sbma_pkg::OWN_NONE)
        else $error("park on last active failed");

    a_park_prio: assert property (
        !cpu_req && !dma_req && cfg.park_select |=> ptr_r == $past(top_prio))
        else $error("park on top priority failed");

    a_boost_on: assert property (
        owner_r == sbma_pkg::OWN_NONE && cpu_req && dma_req && cfg.fixed_mode && !any_lock
        && cfg.boost_en && dma_boost_req |=> owner_r == sbma_pkg::OWN_DMA)
        else $error("boost did not raise dma");

    a_boost_off: assert property (
        owner_r == sbma_pkg::OWN_NONE && cpu_req && dma_req && cfg.fixed_mode && !any_lock
        && !cfg.boost_en && cfg.cpu_prio > cfg.dma_prio |=> owner_r == sbma_pkg::OWN_CPU)
        else $error("boost acted while disabled");

    a_rr_no_lock: assert property (!cfg.fixed_mode |=> lock_v == '0)
        else $error("lock in round-robin mode");

    a_fixed_hold: assert property (
        cfg.fixed_mode && !any_lock && owner_r != sbma_pkg::OWN_NONE && own_req
        |=> owner_r == $past(owner_r))
        else $error("fixed owner lost the bus");

    a_rr_rotate_cpu: assert property (
        !cfg.fixed_mode && owner_r == sbma_pkg::OWN_CPU && bus_xfer_done && dma_req
        |=> owner_r == sbma_pkg::OWN_DMA)
        else $error("round-robin did not rotate to dma");

    a_grant_latency: assert property (
        owner_r == sbma_pkg::OWN_NONE && (cpu_req || dma_req) |=> owner_r != sbma_pkg::OWN_NONE)
        else $error("free bus not granted");

    a_timeout_off: assert property (!cfg.timeout_en |=> lock_v == '0)
        else $error("lock while timeout disabled");

    // main scenarios

    c_rr_handover: cover property (!cfg.fixed_mode && dma_gnt && bus_xfer_done && cpu_req ##1 cpu_gnt);
    c_lock_switch: cover property (cfg.fixed_mode && any_lock ##[1:40] !any_lock);
    c_park_prio: cover property (cfg.park_select && !cpu_req && !dma_req ##1 arb_ptr == sbma_pkg::OWN_DMA);
    c_boost_win: cover property (boost_act && cpu_req && dma_req ##1 dma_gnt);
    c_fixed_keep: cover property (cfg.fixed_mode && !any_lock && dma_gnt && bus_xfer_done && cpu_req ##1 dma_gnt);

endmodule : sbma_arbiter
`default_nettype wire

// *** sbma_master_model.sv ***
`default_nettype none
module sbma_master_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       load,
    input  wire logic [3:0] cpu_cnt,
    input  wire logic [3:0] dma_cnt,
    input  wire logic [1:0] xlen,
    input  wire logic       boost,
    input  wire logic       cpu_gnt,
    input  wire logic       dma_gnt,
    output logic            cpu_req,
    output logic            dma_req,
    output logic            dma_boost_req,
    output logic            bus_xfer_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cpu_left_r;
    logic [3:0] dma_left_r;
    logic [1:0] ph_r;
    logic       busy;

    // requests stay up while transfers remain, a holder never lets go early
    assign cpu_req       = (cpu_left_r != 4'h0);
    assign dma_req       = (dma_left_r != 4'h0);
    assign dma_boost_req = boost & dma_req;
    assign busy          = (cpu_gnt & cpu_req) | (dma_gnt & dma_req);
    assign bus_xfer_done = busy & (ph_r == xlen);

    // a transfer lasts xlen+1 granted cycles; zero gives back-to-back ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_left_r <= 4'h0;
            dma_left_r <= 4'h0;
            ph_r       <= 2'h0;
        end
        else
        begin
            ph_r <= (busy && ph_r != xlen) ? ph_r + 2'h1 : 2'h0;
            if (load)
            begin
                cpu_left_r <= cpu_cnt;
                dma_left_r <= dma_cnt;
            end
            else if (bus_xfer_done)
            begin
                if (cpu_gnt)
                    cpu_left_r <= cpu_left_r - 4'h1;
                if (dma_gnt)
                    dma_left_r <= dma_left_r - 4'h1;
            end
        end
    end
endmodule : sbma_master_model
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic        pready, pslverr, er, fd, load = 1'b0, boost = 1'b0;
    logic        cpu_req, dma_req, dma_boost_req, bus_xfer_done, cpu_gnt, dma_gnt, wide, bst_en;
    logic        pc, pd, pcr, pdr, pdone;
    logic [3:0]  cpu_cnt = 4'h0, dma_cnt = 4'h0;
    logic [1:0]  xlen = 2'h1;
    sbma_pkg::sbma_owner_t arb_ptr;
    int          num_errors = 0, n_compared = 0, cpu_rises = 0, tc, nr;

    sbma_arbiter sbma_arbiter_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_req(cpu_req), .dma_req(dma_req), .dma_boost_req(dma_boost_req),
        .bus_xfer_done(bus_xfer_done), .cpu_gnt(cpu_gnt), .dma_gnt(dma_gnt), .arb_ptr(arb_ptr),
        .dma_wide_byte_count(wide), .dma_bandwidth_boost_enable(bst_en));
    sbma_master_model sbma_master_model_inst (.pclk(pclk), .presetn(presetn), .load(load),
        .cpu_cnt(cpu_cnt), .dma_cnt(dma_cnt), .xlen(xlen), .boost(boost), .cpu_gnt(cpu_gnt),
        .dma_gnt(dma_gnt), .cpu_req(cpu_req), .dma_req(dma_req), .dma_boost_req(dma_boost_req),
        .bus_xfer_done(bus_xfer_done));

    // 100 MHz bus clock
    always #5 pclk = ~pclk;

    task automatic tally_and_finish;
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk

    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] park(input logic f, t, k, input logic [3:0] e,
                                         input logic [1:0] cp, dp, input logic b, w);
        return {6'h00, b, w, 2'h0, dp, cp, 3'h0, f, t, k, e, 8'h00};
    endfunction : park

    // write the park word, read it back, see the dma side outputs follow
    task automatic setp(input logic [31:0] x);
        apb(1'b1, sbma_pkg::PARK_OFFS, x);
        chk("park write err", 32'h0, er);
        apb(1'b0, sbma_pkg::PARK_OFFS, 32'h0);
        chk("park readback", x & sbma_pkg::PARK_WMASK, rd);
        chk("wide count out", x[24], wide);
        chk("boost enable out", x[25], bst_en);
    endtask : setp

    // load both requesters and follow the episode until the bus is idle
    task automatic run(input logic [3:0] cn, dn, input logic [1:0] xl, input logic bs);
        int  r0;
        logic seen;
        r0 = cpu_rises;
        seen = 1'b0;
        fd = 1'bx;
        tc = -1;
        @(posedge pclk);
        cpu_cnt <= cn;
        dma_cnt <= dn;
        xlen    <= xl;
        boost   <= bs;
        load    <= 1'b1;
        @(posedge pclk);
        load    <= 1'b0;
        for (int i = 0; i < 300; i++)
        begin
            @(negedge pclk);
            if (!seen && (cpu_gnt === 1'b1 || dma_gnt === 1'b1))
            begin
                fd = dma_gnt;
                seen = 1'b1;
            end
            if (tc < 0 && cpu_gnt === 1'b1)
                tc = i;
            if (!cpu_req && !dma_req && !cpu_gnt && !dma_gnt)
                break;
        end
        @(negedge pclk);
        chk("episode idle", 32'h0, {cpu_req, dma_req, cpu_gnt, dma_gnt});
        nr = cpu_rises - r0;
    endtask : run

    // grant watcher: one owner, handover only after a done or a dropped request
    always @(negedge pclk)
    begin
        if (presetn)
        begin
            chk("single grant", 32'h0, cpu_gnt & dma_gnt);
            if ((pc && dma_gnt) || (pd && cpu_gnt))
                chk("handover cause", 32'h1, pdone || (pc && !pcr) || (pd && !pdr));
            if (cpu_gnt && !pc)
                cpu_rises++;
        end
        pc = cpu_gnt;
        pd = dma_gnt;
        pcr = cpu_req;
        pdr = dma_req;
        pdone = bus_xfer_done;
    end

    // watchdog sized well past the longest test sequence
    initial
    begin
        #400000;
        num_errors++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        void'($urandom(52056));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("reset ptr", sbma_pkg::OWN_DMA, arb_ptr);
        chk("reset outs", 32'h0, {wide, bst_en, cpu_gnt, dma_gnt});
        apb(1'b0, sbma_pkg::PARK_OFFS, 32'h0);
        chk("park reset", sbma_pkg::PARK_RESET, rd);
        apb(1'b0, sbma_pkg::STAT_OFFS, 32'h0);
        chk("status reset", {28'h0000000, sbma_pkg::OWN_DMA, sbma_pkg::OWN_NONE}, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped err", 32'h1, {rd != 32'h0, er});
        apb(1'b1, sbma_pkg::STAT_OFFS, 32'h0);
        chk("status write err", 32'h1, er);
        run(4'h3, 4'h3, 2'h1, 1'b0);
        chk("reset first dma", 32'h1, fd);
        chk("rr rotations", 32'h3, nr);
        for (int i = 0; i < 5; i++)
        begin
            v = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            setp(v);
        end
        for (int i = 0; i < 16; i++)
        begin
            setp(park(1'b1, 1'b0, 1'b0, 4'h0, i[1:0], i[3:2], 1'b0, 1'b0));
            run(4'h2, 4'h2, 2'h1, 1'b0);
            chk("fixed winner", i[3:2] >= i[1:0], fd);
            chk("fixed hold", 32'h1, nr);
        end
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            setp(park(1'b0, v[0], v[1], v[7:4], v[9:8], v[11:10], 1'b0, v[2]));
            run(4'h3, 4'h3, v[13:12], 1'b0);
            chk("rr with timeout bits", 32'h3, nr);
        end
        for (int e = 0; e < 4; e++)
        begin
            setp(park(1'b1, 1'b1, 1'b0, e[3:0], 2'h0, 2'h3, 1'b0, 1'b0));
            run(4'h1, 4'hF, 2'h1, 1'b0);
            chk("lockout wait", 32'h1, tc > (1 << e) && tc <= (1 << e) + 6);
        end
        setp(park(1'b1, 1'b0, 1'b0, 4'h0, 2'h0, 2'h3, 1'b0, 1'b0));
        run(4'h1, 4'hF, 2'h1, 1'b0);
        chk("no timeout wait", 32'h1, tc > 28);
        setp(park(1'b0, 1'b0, 1'b0, 4'h0, 2'h0, 2'h0, 1'b0, 1'b0));
        run(4'h1, 4'h0, 2'h0, 1'b0);
        chk("park last cpu", sbma_pkg::OWN_CPU, arb_ptr);
        run(4'h0, 4'h1, 2'h2, 1'b0);
        chk("park last dma", sbma_pkg::OWN_DMA, arb_ptr);
        for (int j = 0; j < 2; j++)
        begin
            setp(park(1'b1, 1'b0, 1'b1, 4'h0, j ? 2'h1 : 2'h3, j ? 2'h3 : 2'h1, 1'b0, 1'b0));
            run(j ? 4'h1 : 4'h0, j ? 4'h0 : 4'h1, 2'h1, 1'b0);
            chk("park highest", j ? sbma_pkg::OWN_DMA : sbma_pkg::OWN_CPU, arb_ptr);
        end
        for (int b = 0; b < 2; b++)
        begin
            setp(park(1'b1, 1'b0, 1'b0, 4'h0, 2'h3, 2'h0, b[0], 1'b0));
            run(4'h2, 4'h2, 2'h1, 1'b1);
            chk("boost winner", b[0], fd);
        end
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
